//--- fsa_annunciator.sv
/*
 * Fault status annunciator top: turns alarm, warning and error events into
 * the status LEDs, operator display, panel code, alarm and warning outputs,
 * servo enable gating and the two status read answers.
 * Assumes all inputs are synchronous to core_clk_in; error sources are
 * one-cycle pulses, alarm and warning are levels held by their sources.
 */
// How it works
// - Alarm forces servo drive off while present.
// - Alarm: green LED dark, red LED lit.
// - Alarm code steady in status mode, else 2s.
// - Alarm: panel shows alarm code for drive alarms, else generic alarm code; read returns the alarm code.
// - Alarm output active; warning off; error read kept.
// - Any negative acknowledge counts as error event.
// - Error indications held 2s, then released.
// - Errors never switch servo drive off.
// - Error flashes red LED for 2s.
// - Error code on operator display 2s.
// - Error panel shows generic error code 2s.
// - Error updates last-error read; alarm things unchanged.
// - Error asserts warning output for 2s.
// - Warnings never switch servo drive off.
// - Warning flashes red LED continuously.
// - Warning code steady in status mode, else 2s.
// - Warning panel shows warning code; read returns it.
// - Warning keeps warning output active, others unchanged.
// - Idle: green lit, red dark, outputs inactive.
`timescale 1ns/1ps
`default_nettype none
module fsa_annunciator #(
    parameter int unsigned HOLD_CYCLES  = fsa_pkg::HOLD_CYCLES,
    parameter int unsigned FLASH_CYCLES = fsa_pkg::FLASH_CYCLES
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        alarm_in,
    input  wire logic        drive_alarm_in,
    input  wire logic [7:0]  alarm_code_in,
    input  wire logic        warning_in,
    input  wire logic [7:0]  warning_code_in,
    input  wire logic        nack_input_in,
    input  wire logic        nack_serial_in,
    input  wire logic        nack_operator_in,
    input  wire logic [7:0]  error_code_in,
    input  wire logic [7:0]  status_code_in,
    input  wire logic        status_mode_in,
    input  wire logic        servo_on_req_in,
    input  wire logic        alarm_warning_read_in,
    input  wire logic        error_read_in,
    output logic             servo_enable_out,
    output logic             led_green_out,
    output logic             led_red_out,
    output logic             op_disp_show_out,
    output logic [7:0]       op_disp_code_out,
    output logic [7:0]       panel_code_out,
    output logic             alarm_out,
    output logic             warn_n_out,
    output logic             read_valid_out,
    output logic [7:0]       read_data_out
);
    localparam logic [fsa_pkg::CNT_W-1:0] HOLD_W  = fsa_pkg::CNT_W'(HOLD_CYCLES);
    localparam logic [fsa_pkg::CNT_W-1:0] FLASH_W = fsa_pkg::CNT_W'(FLASH_CYCLES);
    // The event cycle is itself the first cycle of a hold, so timers load one less
    localparam logic [fsa_pkg::CNT_W-1:0] HOLD_LOAD = HOLD_W - 1'b1;

    // Reset release synchroniser
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= fsa_pkg::RST_SYNC_RESET;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    fsa_timer_if err_tmr ();
    fsa_timer_if alm_tmr ();
    fsa_timer_if wrn_tmr ();

    fsa_hold_timer #(.CYCLES(HOLD_LOAD)) u_err_hold (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_n),
        .tmr      (err_tmr.timer)
    );
    fsa_hold_timer #(.CYCLES(HOLD_LOAD)) u_alm_hold (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_n),
        .tmr      (alm_tmr.timer)
    );
    fsa_hold_timer #(.CYCLES(HOLD_LOAD)) u_wrn_hold (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_n),
        .tmr      (wrn_tmr.timer)
    );

    // Event detection
    logic       error_event;
    logic       err_any;
    logic       alarm_prev_q;
    logic       warning_prev_q;
    logic [7:0] last_err_q;
    logic [7:0] last_err_d;

    assign error_event   = nack_input_in | nack_serial_in | nack_operator_in;
    assign err_any       = error_event | err_tmr.active;
    assign err_tmr.start = error_event;
    assign alm_tmr.start = alarm_in & ~alarm_prev_q;
    assign wrn_tmr.start = warning_in & ~warning_prev_q;

    always_comb begin
        last_err_d = last_err_q;
        if (error_event) begin
            last_err_d = error_code_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            alarm_prev_q   <= 1'b0;
            warning_prev_q <= 1'b0;
            last_err_q     <= fsa_pkg::CODE_RESET;
        end else begin
            alarm_prev_q   <= alarm_in;
            warning_prev_q <= warning_in;
            last_err_q     <= last_err_d;
        end
    end

    // Red LED flash divider; free running so every flash has a fixed rhythm
    logic [fsa_pkg::CNT_W-1:0] flash_cnt_q;
    logic [fsa_pkg::CNT_W-1:0] flash_cnt_d;
    logic                      flash_ph_q;
    logic                      flash_ph_d;

    always_comb begin
        flash_cnt_d = flash_cnt_q - 1'b1;
        flash_ph_d  = flash_ph_q;
        if (flash_cnt_q == '0) begin
            flash_cnt_d = FLASH_W - 1'b1;
            flash_ph_d  = ~flash_ph_q;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_q <= '0;
            flash_ph_q  <= 1'b0;
        end else begin
            flash_cnt_q <= flash_cnt_d;
            flash_ph_q  <= flash_ph_d;
        end
    end

    // Indication outputs, all registered
    logic       servo_en_d;
    logic       green_d;
    logic       red_d;
    logic       op_show_d;
    logic [7:0] op_code_d;
    logic [7:0] panel_d;
    logic       alarm_d;
    logic       warn_n_d;
    logic       rd_valid_d;
    logic [7:0] rd_data_d;

    always_comb begin
        servo_en_d = servo_on_req_in & ~alarm_in;
        green_d    = 1'b1;
        red_d      = 1'b0;
        op_show_d  = 1'b0;
        op_code_d  = status_code_in;
        panel_d    = status_code_in;
        alarm_d    = alarm_in;
        warn_n_d   = 1'b1;
        if (alarm_in) begin
            green_d   = 1'b0;
            red_d     = 1'b1;
            op_show_d = status_mode_in | alm_tmr.start | alm_tmr.active;
            op_code_d = alarm_code_in;
            panel_d   = drive_alarm_in ? alarm_code_in : fsa_pkg::PANEL_ALARM_GEN;
        end else if (err_any) begin
            green_d   = 1'b0;
            red_d     = flash_ph_q;
            op_show_d = 1'b1;
            op_code_d = error_event ? error_code_in : last_err_q;
            panel_d   = fsa_pkg::PANEL_ERROR_GEN;
            warn_n_d  = 1'b0;
        end else if (warning_in) begin
            green_d   = 1'b0;
            red_d     = flash_ph_q;
            op_show_d = status_mode_in | wrn_tmr.start | wrn_tmr.active;
            op_code_d = warning_code_in;
            panel_d   = warning_code_in;
            warn_n_d  = 1'b0;
        end
        rd_valid_d = alarm_warning_read_in | error_read_in;
        // The answer stands until the next read command replaces it
        rd_data_d  = read_data_out;
        if (error_read_in) begin
            rd_data_d = last_err_q;
        end else if (alarm_warning_read_in) begin
            if (alarm_in) begin
                rd_data_d = alarm_code_in;
            end else if (warning_in) begin
                rd_data_d = warning_code_in;
            end else begin
                rd_data_d = status_code_in;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            servo_enable_out <= 1'b0;
            led_green_out    <= 1'b1;
            led_red_out      <= 1'b0;
            op_disp_show_out <= 1'b0;
            op_disp_code_out <= fsa_pkg::CODE_RESET;
            panel_code_out   <= fsa_pkg::CODE_RESET;
            alarm_out        <= 1'b0;
            warn_n_out       <= 1'b1;
            read_valid_out   <= 1'b0;
            read_data_out    <= fsa_pkg::CODE_RESET;
        end else begin
            servo_enable_out <= servo_en_d;
            led_green_out    <= green_d;
            led_red_out      <= red_d;
            op_disp_show_out <= op_show_d;
            op_disp_code_out <= op_code_d;
            panel_code_out   <= panel_d;
            alarm_out        <= alarm_d;
            warn_n_out       <= warn_n_d;
            read_valid_out   <= rd_valid_d;
            read_data_out    <= rd_data_d;
        end
    end

    chk_servo_off_alarm: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        alarm_in |=> !servo_enable_out)
        else $error("servo enabled during alarm");
    chk_servo_kept_on: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (servo_on_req_in && !alarm_in) |=> servo_enable_out)
        else $error("servo dropped without alarm");
    chk_led_alarm: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        alarm_in |=> (led_red_out && !led_green_out))
        else $error("alarm LED pattern wrong");
    chk_alarm_outputs: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (alarm_in && !error_event) |=> (alarm_out && warn_n_out && $stable(last_err_q)))
        else $error("alarm outputs wrong");
    chk_op_alarm_steady: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (alarm_in && status_mode_in) |=>
            (op_disp_show_out && op_disp_code_out == $past(alarm_code_in)))
        else $error("alarm code not on operator display");
    chk_panel_alarm: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (alarm_in && !drive_alarm_in) |=> panel_code_out == fsa_pkg::PANEL_ALARM_GEN)
        else $error("generic alarm panel code missing");
    chk_err_warn_out: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (error_event && !alarm_in) ##1 !alarm_in [*2] |-> !warn_n_out)
        else $error("warning output not held after error");
    chk_err_code_read: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        error_event ##1 error_read_in |=>
            (read_valid_out && read_data_out == $past(error_code_in, 2)))
        else $error("last error code not returned");
    chk_warn_steady: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (warning_in && !alarm_in) |=> (!warn_n_out && !alarm_out))
        else $error("warning output not active");
    chk_idle_state: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (!alarm_in && !warning_in && !err_any) |=>
            (led_green_out && !led_red_out && !alarm_out && warn_n_out))
        else $error("idle indications wrong");
    chk_alarm_show_hold: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        $rose(alarm_in) |=>
            (op_disp_show_out && op_disp_code_out == $past(alarm_code_in)))
        else $error("alarm code not shown at alarm onset");
    chk_warn_show_hold: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        ($rose(warning_in) && !alarm_in && !err_any) |=>
            (op_disp_show_out && op_disp_code_out == $past(warning_code_in)))
        else $error("warning code not shown at warning onset");
    chk_err_display: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (error_event && !alarm_in) |=>
            (op_disp_show_out && op_disp_code_out == $past(error_code_in)))
        else $error("error code not on operator display");
    chk_panel_error: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (error_event && !alarm_in) |=> panel_code_out == fsa_pkg::PANEL_ERROR_GEN)
        else $error("generic error panel code missing");
    chk_alarm_read: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (alarm_warning_read_in && !error_read_in && alarm_in) |=>
            (read_valid_out && read_data_out == $past(alarm_code_in)))
        else $error("alarm code not returned");
    chk_read_kept: assert property (
        @(posedge core_clk_in) disable iff (!rst_n)
        (!alarm_warning_read_in && !error_read_in) |=> $stable(read_data_out))
        else $error("read answer changed without a read");
endmodule // fsa_annunciator
`default_nettype wire

//--- fsa_pkg.sv
/*
 * Shared constants for the fault status annunciator: panel codes, widths,
 * and the hold and flash timing figures.
 * Assumes a single 20 MHz core clock.
 */
package fsa_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CNT_W           = 26;
    localparam int unsigned CODE_W          = 8;
    // Indication hold after an error, or after alarm/warning onset
    localparam int unsigned HOLD_TIME_MS    = 2000;
    localparam int unsigned HOLD_CYCLES     = HOLD_TIME_MS * (CLK_HZ / 1000);
    // Half period of the red LED flash
    localparam int unsigned FLASH_HALF_MS   = 250;
    localparam int unsigned FLASH_CYCLES    = FLASH_HALF_MS * (CLK_HZ / 1000);
    localparam logic [7:0]  PANEL_ALARM_GEN = 8'hEF;
    localparam logic [7:0]  PANEL_ERROR_GEN = 8'h9F;
    localparam logic [7:0]  CODE_RESET      = 8'h00;
    localparam logic [1:0]  RST_SYNC_RESET  = 2'h0;
endpackage

//--- fsa_timer_if.sv
/*
 * Carrier between the annunciator core and one hold timer.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface fsa_timer_if;
    logic start;
    logic active;
    modport owner (output start, input active);
    modport timer (input start, output active);
endinterface // fsa_timer_if
`default_nettype wire

//--- fsa_hold_timer.sv
/*
 * Retriggerable hold timer: a start pulse (re)loads the count, and active
 * stays high until the count runs out.
 * Assumes start is a one-cycle pulse synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module fsa_hold_timer #(
    parameter logic [fsa_pkg::CNT_W-1:0] CYCLES = fsa_pkg::CNT_W'(fsa_pkg::HOLD_CYCLES)
) (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    fsa_timer_if.timer tmr
);
    logic [fsa_pkg::CNT_W-1:0] cnt_q;
    logic [fsa_pkg::CNT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (tmr.start) begin
            cnt_d = CYCLES;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tmr.active = (cnt_q != '0);

    chk_hold_reload: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        tmr.start |=> (cnt_q == CYCLES) && tmr.active)
        else $error("hold timer did not reload on start");
endmodule // fsa_hold_timer
`default_nettype wire

//--- fsa_host_model.sv
/*
 * Host and operator side model: issues the two status read commands one
 * cycle after the bench asks, and keeps the last answer it received.
 * Assumes one core clock shared with the annunciator.
 */
`timescale 1ns/1ps
`default_nettype none
module fsa_host_model (
    input  wire logic       clk_in,
    input  wire logic       aw_req_in,
    input  wire logic       err_req_in,
    input  wire logic       read_valid_in,
    input  wire logic [7:0] read_data_in,
    output logic            aw_strobe_out,
    output logic            err_strobe_out,
    output logic [7:0]      last_answer_out
);
    logic r_aw;
    logic r_err;

    // Requests are sampled on the edge so bench updates never race them
    always @(posedge clk_in) begin
        r_aw = aw_req_in;
        r_err = err_req_in;
        if (read_valid_in) last_answer_out <= read_data_in;
        #1;
        aw_strobe_out = r_aw;
        err_strobe_out = r_err;
    end
endmodule // fsa_host_model
`default_nettype wire

//--- fsa_annunciator_bench.sv
/*
 * Self-checking bench for fsa_annunciator: random fault traffic compared
 * every cycle with a behavioural model. Assumes fsa_host_model for reads.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module fsa_annunciator_bench;
    localparam int HOLD = 40;
    localparam int FLASH = 4;
    logic       clk = 1'b0, rst_n = 1'b0, alarm = 1'b0, drv_alm = 1'b0;
    logic       warning = 1'b0, nk_in = 1'b0, nk_ser = 1'b0, nk_op = 1'b0;
    logic       st_mode = 1'b0, srv_req = 1'b0, aw_req = 1'b0, err_req = 1'b0;
    logic [7:0] alm_code = 8'h00, wrn_code = 8'h00, err_code = 8'h00;
    logic [7:0] sts_code = 8'h00, dcode, pnl, rd, ans, e_code, e_pnl, e_rd, last_err;
    logic       rd_aw, rd_err, srv, grn, red, show, alarm_warning_read, warn_n, rv;
    logic       e_srv, e_grn, e_wn, e_rv, e_red, e_alm;
    logic [7:0] e_ans;
    int         err_left, err_count = 0, checked = 0, cycles = 0, fl_cnt = 0;
    bit         live = 0, busy, dchk, achk = 0, fl_ph = 0;
    bit   [1:0] rs = 2'h0;

    fsa_annunciator #(.HOLD_CYCLES(HOLD), .FLASH_CYCLES(FLASH)) dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .alarm_in(alarm),
        .drive_alarm_in(drv_alm), .alarm_code_in(alm_code), .warning_in(warning),
        .warning_code_in(wrn_code), .nack_input_in(nk_in), .nack_serial_in(nk_ser),
        .nack_operator_in(nk_op), .error_code_in(err_code), .status_code_in(sts_code),
        .status_mode_in(st_mode), .servo_on_req_in(srv_req),
        .alarm_warning_read_in(rd_aw), .error_read_in(rd_err),
        .servo_enable_out(srv), .led_green_out(grn), .led_red_out(red),
        .op_disp_show_out(show), .op_disp_code_out(dcode), .panel_code_out(pnl),
        .alarm_out(alarm_warning_read), .warn_n_out(warn_n), .read_valid_out(rv), .read_data_out(rd));

    fsa_host_model host (
        .clk_in(clk), .aw_req_in(aw_req), .err_req_in(err_req), .read_valid_in(rv),
        .read_data_in(rd), .aw_strobe_out(rd_aw), .err_strobe_out(rd_err),
        .last_answer_out(ans));

    always #25 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            end_of_test();
        end
    end

    // Expected registered outputs, from the inputs seen at each edge
    always @(posedge clk) begin
        e_rv = 1'b0;
        if (!rst_n) begin
            err_left = 0;
            last_err = 8'h00;
            e_rd = 8'h00;
        end else begin
            e_rv = rd_aw | rd_err;
            if (rd_err) e_rd = last_err;
            else if (rd_aw) e_rd = alarm ? alm_code : warning ? wrn_code : sts_code;
            if (nk_in | nk_ser | nk_op) begin
                err_left = HOLD;
                last_err = err_code;
            end else if (err_left > 0) err_left--;
        end
        busy = alarm || err_left > 0 || warning;
        e_srv = srv_req & !alarm;
        e_grn = !busy;
        e_alm = alarm;
        e_red = alarm || (busy && fl_ph);
        e_wn = !(!alarm && (warning || err_left > 0));
        e_pnl = alarm ? (drv_alm ? alm_code : fsa_pkg::PANEL_ALARM_GEN) :
                err_left > 0 ? fsa_pkg::PANEL_ERROR_GEN : warning ? wrn_code : sts_code;
        dchk = alarm ? st_mode : (err_left > 0) ? 1'b1 : (warning & st_mode);
        e_code = alarm ? alm_code : (err_left > 0) ? last_err : wrn_code;
        // Free running flash, restarted when the two-flop reset copy releases
        if (rs[1]) begin
            fl_ph ^= (fl_cnt == 0);
            fl_cnt = (fl_cnt == 0) ? FLASH - 1 : fl_cnt - 1;
        end else begin
            fl_cnt = 0;
            fl_ph = 1'b0;
        end
        rs = rst_n ? {rs[0], 1'b1} : 2'h0;
    end

    task automatic do_reset();
        @(posedge clk);
        #1;
        live = 0;
        achk = 0;
        {alarm, warning, aw_req, err_req, nk_in, nk_ser, nk_op} = 7'h0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        live = 1;
    endtask

    // Probabilities are per mille per cycle
    task automatic run(input int n, input int pa, input int pw, input int pn);
        repeat (n) begin
            @(posedge clk);
            #1;
            if (live) begin
                `CHK("servo", e_srv, srv)
                `CHK("green", e_grn, grn)
                `CHK("red", e_red, red)
                `CHK("alarm", e_alm, alarm_warning_read)
                `CHK("warn", e_wn, warn_n)
                `CHK("panel", e_pnl, pnl)
                `CHK("valid", e_rv, rv)
                `CHK("data", e_rd, rd)
                if (achk) `CHK("answer", e_ans, ans)
                if (dchk) `CHK("show", 1'b1, show)
                if (dchk) `CHK("code", e_code, dcode)
                if (!busy) `CHK("idle show", 1'b0, show)
                achk = e_rv;
                e_ans = e_rd;
            end
            if ($urandom_range(999) < pa) alarm = ~alarm;
            if ($urandom_range(999) < pw) warning = ~warning;
            if ($urandom_range(99) < 3) st_mode = ~st_mode;
            {nk_in, nk_ser, nk_op} = ($urandom_range(999) < pn) ?
                3'h1 << $urandom_range(2) : 3'h0;
            drv_alm = 1'($urandom);
            srv_req = 1'($urandom);
            alm_code = 8'($urandom);
            wrn_code = 8'($urandom);
            err_code = 8'($urandom);
            sts_code = 8'($urandom);
            aw_req = ($urandom_range(9) == 0);
            err_req = ($urandom_range(9) == 0);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        void'($urandom(70204));
        do_reset();
        run(300, 0, 0, 0);
        run(600, 0, 0, 20);
        run(30, 0, 0, 400);
        run(600, 0, 5, 15);
        run(900, 5, 5, 15);
        do_reset();
        run(400, 5, 5, 30);
        end_of_test();
    end
endmodule // fsa_annunciator_bench
`default_nettype wire
